/* File: logic/bafd_decoder.sv */
/*
 * bit aligned instruction field decoder: shift buffer, field parser,
 * operand role resolution and hand-off record for the sequencer.
 * assumes fetch words arrive lsb-first in stream order, same clock.
 */
`timescale 1ns/1ns
module bafd_decoder
    import bafd_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // instruction fetch
    input  wire logic [31:0] fetch_data_in,
    input  wire logic        fetch_valid_in,
    output logic             fetch_ready_out,
    // sequencer hand-off
    output bafd_instr_t      instr_out,
    output logic             instr_valid_out,
    input  wire logic        instr_ready_in
);

    // =====================================================
    // state
    bafd_state_t s_q;
    bafd_state_t s_d;
    logic [6:0]  take;

    // payload width per selector mode
    function automatic logic [6:0] pay_len(input bafd_sel_t sel);
        case (sel)
            SEL_SHORT_DIR: pay_len = 7'(PAY_SHORT_DIR);
            SEL_LONG_DIR:  pay_len = 7'(PAY_LONG_DIR);
            SEL_STACK_IND: pay_len = 7'(PAY_STACK_IND);
            default:       pay_len = 7'(PAY_GEN_IND);
        endcase
    endfunction : pay_len

    // =====================================================
    // next state
    always_comb begin
        logic       is_long;
        logic [6:0] len;
        logic [6:0] after;
        logic       accept;
        bafd_sel_t  sel;
        logic       dst;
        logic       ex;
        logic       slot_dst;
        logic [1:0] pops;
        logic [2:0] emask;
        logic [63:0] sh;
        is_long = 1'b0;
        len     = '0;
        after   = '0;
        accept  = 1'b0;
        sel     = SEL_SHORT_DIR;
        dst     = 1'b0;
        ex      = 1'b0;
        slot_dst = 1'b0;
        pops    = '0;
        emask   = '0;
        sh      = '0;
        s_d     = s_q;
        take    = '0;
        // sequencer takes the pending record
        if (s_q.out_valid && instr_ready_in) begin
            s_d.out_valid = 1'b0;
        end
        case (s_q.st)
            ST_CLASS: begin
                is_long = (s_q.sbuf[1:0] == 2'h3);
                len = is_long ? 7'(CLASS_LONG) : 7'(CLASS_SHORT);
                if (s_q.cnt >= len) begin
                    take = len;
                    // count and type of operands
                    if (is_long) begin
                        s_d.otype = {1'b1, s_q.sbuf[3:2]};
                        s_d.nops  = s_q.sbuf[5:4];
                    end else begin
                        s_d.otype = {1'b0, s_q.sbuf[1:0]};
                        s_d.nops  = s_q.sbuf[3:2];
                    end
                    s_d.nexp    = '0;
                    s_d.shared  = 1'b0;
                    s_d.ref_idx = '0;
                    s_d.refs    = '0;
                    // format only follows a class with operands
                    s_d.st = (s_d.nops != 2'h0) ? ST_FORMAT
                                                : ST_OPCODE;
                end
            end
            ST_FORMAT: begin
                if (s_q.cnt >= 7'(FORMAT_BITS)) begin
                    take = 7'(FORMAT_BITS);
                    s_d.nexp = (s_q.sbuf[1:0] > s_q.nops) ? s_q.nops
                                                           : s_q.sbuf[1:0];
                    // one explicit reference as first source and destination
                    s_d.shared   = s_q.sbuf[2] && (s_q.nops >= 2'h2)
                                   && (s_d.nexp != 2'h0);
                    s_d.indirect = s_q.sbuf[3];
                    s_d.st = (s_d.nexp != 2'h0) ? ST_REF
                                                : ST_OPCODE;
                end
            end
            ST_REF: begin
                sel = bafd_sel_t'({s_q.indirect, s_q.sbuf[0]});
                len = 7'(REF_HDR_BITS) + pay_len(sel);
                if (s_q.cnt >= len) begin
                    take = len;
                    s_d.refs[s_q.ref_idx[1:0]].sel = sel;
                    s_d.refs[s_q.ref_idx[1:0]].dsp =
                        bafd_dsp_t'(s_q.sbuf[2:1]);
                    // logical address, masked to the payload width
                    s_d.refs[s_q.ref_idx[1:0]].addr = s_q.sbuf[22:3]
                        & 20'((64'h1 << pay_len(sel)) - 64'h1);
                    s_d.ref_idx = s_q.ref_idx + 3'h1;
                    if (s_d.ref_idx == {1'b0, s_q.nexp}) begin
                        s_d.st = ST_OPCODE;
                    end
                end
            end
            ST_OPCODE: begin
                // waits here while fewer than OPCODE_BITS bits are buffered or the hand-off slot is occupied and not taken this cycle
                if (s_q.cnt >= 7'(OPCODE_BITS)
                    && !s_d.out_valid) begin
                    take = 7'(OPCODE_BITS);
                    for (int i = 0; i < 3; i++) begin
                        slot_dst = (s_q.nops >= 2'h2)
                            && (2'(i) == s_q.nops - 2'h1);
                        ex = (2'(i) < s_q.nops) && ((2'(i) < s_q.nexp)
                            || (s_q.shared && slot_dst));
                        emask[i] = ex;
                        if ((2'(i) < s_q.nops) && !ex) begin
                            if (slot_dst) begin
                                dst = 1'b1;
                            end else begin
                                pops = pops + 2'h1;
                            end
                        end
                    end
                    s_d.out_valid = 1'b1;
                    s_d.out.otype = s_q.otype;
                    s_d.out.nops  = s_q.nops;
                    s_d.out.explicit_mask = emask;
                    s_d.out.pops  = pops;
                    s_d.out.push  = dst;
                    s_d.out.refs  = s_q.refs;
                    s_d.out.uaddr =
                        {s_q.otype, s_q.sbuf[4:0], UADDR_PAD};
                    s_d.out.is_micro =
                        (s_q.sbuf[4:0] < SIMPLE_OPC_LIMIT);
                    s_d.out.uinstr = UINSTR_BASE
                        | {8'h00, s_q.otype, s_q.sbuf[4:0]};
                    s_d.st = ST_CLASS;
                end
            end
            default: s_d.st = ST_CLASS;
        endcase
        // shift out consumed bits, append a fetched word behind the rest
        after  = s_q.cnt - take;
        accept = s_q.fetch_rdy && fetch_valid_in;
        sh     = s_q.sbuf >> take;
        if (accept) begin
            sh = sh | (64'(fetch_data_in) << after);
        end
        s_d.sbuf = sh;
        s_d.cnt  = after + (accept ? 7'(WORD_BITS) : 7'h00);
        s_d.fetch_rdy = (s_d.cnt < 7'(MAX_FIELD_BITS));
    end

    // =====================================================
    // state register
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q           <= '0;
            s_q.st        <= ST_CLASS;
            s_q.fetch_rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign fetch_ready_out = s_q.fetch_rdy;
    assign instr_out       = s_q.out;
    assign instr_valid_out = s_q.out_valid;

    // =====================================================
    // assertions
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_class_len;
        (s_q.st == ST_CLASS && take != 7'h00)
            |-> take == ((s_q.sbuf[1:0] == 2'h3) ? 7'h06 : 7'h04);
    endproperty
    a_class_len: assert property (p_class_len)
        else $error("class field length wrong");

    property p_zero_ops;
        (s_q.st == ST_CLASS && take != 7'h00 && s_d.nops == 2'h0)
            |=> s_q.st == ST_OPCODE;
    endproperty
    a_zero_ops: assert property (p_zero_ops)
        else $error("format parsed with zero operands");

    property p_order;
        (s_q.st == ST_CLASS && take != 7'h00 && s_d.nops != 2'h0)
            |=> s_q.st == ST_FORMAT;
    endproperty
    a_order: assert property (p_order)
        else $error("format does not follow class");

    property p_ref_len;
        (s_q.st == ST_REF && take != 7'h00)
            |-> (s_q.indirect ? take <= 7'h0b : take >= 7'h0f);
    endproperty
    a_ref_len: assert property (p_ref_len)
        else $error("reference length does not match kind");

    property p_fetch;
        fetch_ready_out == (s_q.cnt < 7'h17);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch request not tied to fill level");

    property p_hold;
        instr_valid_out && !instr_ready_in
            |=> instr_valid_out && $stable(instr_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pending record changed while stalled");

    property p_micro;
        instr_valid_out
            |-> instr_out.is_micro == (instr_out.uaddr[8:4] < 5'h08);
    endproperty
    a_micro: assert property (p_micro)
        else $error("micro flag does not match opcode");

    property p_roles;
        instr_valid_out |-> $countones(instr_out.explicit_mask)
            + int'(instr_out.pops) + int'(instr_out.push)
            == int'(instr_out.nops);
    endproperty
    a_roles: assert property (p_roles)
        else $error("operand roles do not cover operand count");

    property p_refs_done;
        (s_q.st == ST_REF) ##1 (s_q.st == ST_OPCODE)
            |-> s_q.ref_idx == {1'b0, s_q.nexp};
    endproperty
    a_refs_done: assert property (p_refs_done)
        else $error("reference count differs from format");

    c_micro: cover property (instr_valid_out && instr_out.is_micro);
    c_three: cover property (instr_valid_out && instr_out.nops == 2'h3);
    c_stall: cover property (instr_valid_out && !instr_ready_in
                             && s_q.st == ST_OPCODE);

endmodule : bafd_decoder

/* File: pkg/bafd_pkg.sv */
/*
 * constants, types and state layout for the bit aligned instruction
 * field decoder (first pipeline stage).
 * assumes one clock; the fetch side and the sequencer side are plain
 * same-clock logic with valid/ready handshakes.
 */
// Summary of operation
// - instruction stream is one bit string; fields start at any bit
// - every instruction parsed as class, then format and references when present, then opcode
// - class field is 4 or 6 bits, chosen by its own encoding
// - class gives operand count zero to three and operand type
// - format field present only when class calls for references
// - format marks explicit refs direct or indirect; direct are longer
// - one explicit reference may serve as source and destination
// - operands beyond explicit ones are implicit: popped or pushed
// - no reference bits for implicit operands; count follows format
// - opcode field read last, selects the operator
// - starting addresses of microcode procedures go to the sequencer
// - simple operations produce a microinstruction directly
// - selector modes: short direct, long direct, stack, general indirect
// - displacement modes: scalar, record item, static vector element
// - dynamic vector element is the fourth displacement mode
// - decoder extracts logical operand addresses from references
// - decoding runs ahead of the sequencer, stalling only when full
package bafd_pkg;

    // =====================================================
    // field sizes and buffer
    localparam int BUF_BITS       = 64;
    localparam int WORD_BITS      = 32;
    localparam int MAX_FIELD_BITS = 23;
    localparam int CLASS_SHORT    = 4;
    localparam int CLASS_LONG     = 6;
    localparam int FORMAT_BITS    = 4;
    localparam int REF_HDR_BITS   = 3;
    localparam int OPCODE_BITS    = 5;
    localparam int PAY_SHORT_DIR  = 12;
    localparam int PAY_LONG_DIR   = 20;
    localparam int PAY_STACK_IND  = 4;
    localparam int PAY_GEN_IND    = 8;

    // =====================================================
    // output encodings
    localparam logic [4:0]  SIMPLE_OPC_LIMIT = 5'h08;
    localparam logic [15:0] UINSTR_BASE      = 16'h8000;
    localparam logic [3:0]  UADDR_PAD        = 4'h0;

    // =====================================================
    // types
    typedef enum logic [1:0] {
        SEL_SHORT_DIR = 2'h0,
        SEL_LONG_DIR  = 2'h1,
        SEL_STACK_IND = 2'h2,
        SEL_GEN_IND   = 2'h3
    } bafd_sel_t;

    typedef enum logic [1:0] {
        DSP_SCALAR     = 2'h0,
        DSP_RECORD     = 2'h1,
        DSP_STATIC_VEC = 2'h2,
        DSP_DYN_VEC    = 2'h3
    } bafd_dsp_t;

    typedef enum logic [3:0] {
        ST_CLASS  = 4'h1,
        ST_FORMAT = 4'h2,
        ST_REF    = 4'h4,
        ST_OPCODE = 4'h8
    } bafd_st_t;

    typedef struct packed {
        bafd_sel_t   sel;
        bafd_dsp_t   dsp;
        logic [19:0] addr;
    } bafd_ref_t;

    typedef struct packed {
        logic            is_micro;
        logic [11:0]     uaddr;
        logic [15:0]     uinstr;
        logic [2:0]      otype;
        logic [1:0]      nops;
        logic [2:0]      explicit_mask;
        logic [1:0]      pops;
        logic            push;
        bafd_ref_t [2:0] refs;
    } bafd_instr_t;

    typedef struct packed {
        bafd_st_t        st;
        logic [63:0]     sbuf;
        logic [6:0]      cnt;
        logic [2:0]      otype;
        logic [1:0]      nops;
        logic [1:0]      nexp;
        logic            shared;
        logic            indirect;
        logic [2:0]      ref_idx;
        bafd_ref_t [2:0] refs;
        logic            fetch_rdy;
        logic            out_valid;
        bafd_instr_t     out;
    } bafd_state_t;

endpackage : bafd_pkg

/* File: sim/bafd_seq_model.sv */
/*
 * sequencer stand-in for the decoder's hand-off port.
 * assumes the decoder's clock and reset; slow_in turns on stalls.
 */
`timescale 1ns/1ns
module bafd_seq_model (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // stall control and handshake
    input  wire logic slow_in,
    output logic      ready_out
);
    logic [15:0] lfsr_q;

    // =====================================
    // ready pattern: steady when prompt, one in four when slow
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            lfsr_q    <= 16'hace1;
            ready_out <= 1'b0;
        end else begin
            lfsr_q    <= {lfsr_q[14:0], ^(lfsr_q & 16'hb400)};
            ready_out <= !slow_in || (lfsr_q[1:0] == 2'h3);
        end
    end
endmodule : bafd_seq_model

/* File: sim/bafd_decoder_tb.sv */
/*
 * self-checking bench for the decoder: random bit stream in,
 * records checked against a queue of expected records.
 * assumes the hand-off encoding agreed for the decoder.
 */
`timescale 1ns/1ns
module bafd_decoder_tb
    import bafd_pkg::*;
;
    logic        ref_clk_in     = 1'b0;
    logic        rst_in         = 1'b1;
    logic [31:0] fetch_data_in  = 32'h0;
    logic        fetch_valid_in = 1'b0;
    logic        fetch_ready_out;
    bafd_instr_t instr_out;
    logic        instr_valid_out;
    logic        instr_ready_in;
    logic        slow           = 1'b0;
    int          failures       = 0;
    int          checks_done    = 0;
    int          cycles         = 0;
    int          n_got          = 0;
    logic        bits_q[$];
    bafd_instr_t exp_q[$];
    int          nref_q[$];

    always #2 ref_clk_in = ~ref_clk_in;

    bafd_decoder dut (
        .ref_clk_in      (ref_clk_in),
        .rst_in          (rst_in),
        .fetch_data_in   (fetch_data_in),
        .fetch_valid_in  (fetch_valid_in),
        .fetch_ready_out (fetch_ready_out),
        .instr_out       (instr_out),
        .instr_valid_out (instr_valid_out),
        .instr_ready_in  (instr_ready_in)
    );

    bafd_seq_model seq (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .slow_in    (slow),
        .ready_out  (instr_ready_in)
    );

    // =====================================
    // reporting
    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic stop_test();
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic put(input logic [19:0] v, input int n);
        for (int i = 0; i < n; i++)
            bits_q.push_back(v[i]);
    endtask : put

    // =====================================
    // one instruction: m>=0 walks ref modes, -1 random, -2 padding
    task automatic gen(input int m);
        bafd_instr_t e;
        logic [1:0]  nops, ot, fr, fe;
        logic [2:0]  vd;
        logic [4:0]  opc;
        logic [19:0] pay;
        logic        lng, sh, ind, dst, ex;
        int          plen;
        e    = '0;
        lng  = (m == -1) && $urandom_range(1);
        ot   = (m == -2) ? 2'h0 : 2'($urandom_range(lng ? 3 : 2));
        nops = (m == -1) ? 2'($urandom_range(3)) : 2'(m >= 0);
        fr   = (m == -1) ? 2'($urandom_range(3)) : 2'h1;
        sh   = 1'($urandom_range(1));
        ind  = (m >= 0) ? m[1] : 1'($urandom_range(1));
        opc  = (m == -2) ? 5'h0 : 5'($urandom_range(31));
        if (lng)
            put({14'h0, nops, ot, 2'h3}, 6);
        else
            put({16'h0, nops, ot}, 4);
        if (nops != 2'h0)
            put({16'h0, ind, sh, fr}, 4);
        fe = (fr > nops) ? nops : fr;
        sh = sh && nops >= 2'h2 && fe != 2'h0;
        for (int k = 0; k < fe; k++) begin
            vd   = (m >= 0) ? {m[3:2], m[0]} : 3'($urandom_range(7));
            plen = ind ? (vd[0] ? PAY_GEN_IND : PAY_STACK_IND)
                       : (vd[0] ? PAY_LONG_DIR : PAY_SHORT_DIR);
            pay  = 20'($urandom) & ((20'h1 << plen) - 20'h1);
            put({17'h0, vd}, 3);
            put(pay, plen);
            e.refs[k] = {ind, vd[0], vd[2:1], pay};
        end
        for (int s = 0; s < nops; s++) begin
            dst = nops >= 2'h2 && s == nops - 1;
            ex  = s < fe || (sh && dst);
            e.explicit_mask[s] = ex;
            if (!ex && dst)
                e.push = 1'b1;
            else if (!ex)
                e.pops++;
        end
        put({15'h0, opc}, 5);
        e.otype    = {lng, ot};
        e.nops     = nops;
        e.is_micro = opc < SIMPLE_OPC_LIMIT;
        e.uaddr    = {e.otype, opc, UADDR_PAD};
        e.uinstr   = UINSTR_BASE | {8'h0, e.otype, opc};
        exp_q.push_back(e);
        nref_q.push_back(int'(fe));
    endtask : gen

    // =====================================
    // watcher: each taken record against the oldest note
    always @(posedge ref_clk_in) begin
        bafd_instr_t s;
        bafd_instr_t w;
        if (!rst_in && instr_valid_out && instr_ready_in) begin
            s = instr_out;
            w = '0;
            n_got++;
            if (exp_q.size() > 0) begin
                w = exp_q.pop_front();
                for (int k = nref_q.pop_front(); k < 3; k++)
                    s.refs[k] = '0;
            end
            check(128'(s.refs), 128'(w.refs));
            check(128'(s), 128'(w));
        end
    end

    // hang guard
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    // =====================================
    // main sequence: build stream, reset, feed words
    initial begin
        logic [31:0] words[$];
        logic [31:0] w;
        int          wi;
        int          n_exp;
        logic        v;
        void'($urandom(32'h8346));
        for (int m = 0; m < 16; m++)
            gen(m);
        repeat (300) gen(-1);
        while ((32 - bits_q.size() % 32) % 32 >= 9)
            gen(-2);
        while (bits_q.size() % 32 != 0)
            bits_q.push_back(1'b0);
        while (bits_q.size() > 0) begin
            for (int i = 0; i < 32; i++)
                w[i] = bits_q.pop_front();
            words.push_back(w);
        end
        n_exp = exp_q.size();
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        check(128'(fetch_ready_out), 128'h1);
        check(128'(instr_valid_out), 128'h0);
        wi = 0;
        while (wi < words.size()) begin
            @(posedge ref_clk_in);
            if (fetch_valid_in && fetch_ready_out)
                wi++;
            v = (wi < words.size()) && ((fetch_valid_in && !fetch_ready_out)
                || $urandom_range(3) != 0);
            fetch_valid_in <= v;
            fetch_data_in  <= v ? words[wi] : ~fetch_data_in;
            slow           <= wi > words.size() / 2;
        end
        for (int c = 0; c < 4000 && n_got < n_exp; c++)
            @(posedge ref_clk_in);
        check(128'(n_got), 128'(n_exp));
        stop_test();
    end
endmodule : bafd_decoder_tb
